// file: verilog/dmio_pkg.sv
`default_nettype none
package dmio_pkg;
  localparam int DMIO_LANE_DATA  = 8;
  localparam int DMIO_LANE_PINS  = 9;
  localparam int DMIO_GROUPS     = 2;
  localparam int DMIO_DATA_W     = DMIO_LANE_DATA * DMIO_GROUPS;
  localparam int DMIO_PIN_W      = DMIO_LANE_PINS * DMIO_GROUPS;
  localparam int DMIO_ADDR_W     = 13;
  localparam int DMIO_CMD_W      = 4;
  localparam int DMIO_FIFO_DEPTH = 8;
  localparam int DMIO_DELAY_TAPS = 4;
  localparam int DMIO_TAP_W      = 2;
  localparam int DMIO_CLOCK_MHZ   = 200;
  localparam int DMIO_MEM_DIV     = 2;
  localparam int DMIO_MEM_MHZ     = DMIO_CLOCK_MHZ / DMIO_MEM_DIV;
  localparam int DMIO_MAX_MHZ     = 167;
  localparam int DMIO_MAX_DDR_MBPS = 333;
  localparam int DMIO_MAX_QDR_MBPS = 667;
  localparam logic [DMIO_CMD_W-1:0] DMIO_CMD_NOP = 4'hf;

  typedef enum logic [1:0] {
    DMIO_IDLE  = 2'b00,
    DMIO_PRE   = 2'b01,
    DMIO_WRITE = 2'b10,
    DMIO_POST  = 2'b11
  } dmio_wstate_type;

  typedef struct packed {
    logic [DMIO_PIN_W-1:0] rise;
    logic [DMIO_PIN_W-1:0] fall;
  } dmio_beats_type;

  typedef struct packed {
    logic [DMIO_DATA_W-1:0] rise;
    logic [DMIO_DATA_W-1:0] fall;
    logic [DMIO_GROUPS-1:0] lane_en;
  } dmio_wr_type;

  typedef struct packed {
    logic [DMIO_DATA_W-1:0] rise;
    logic [DMIO_DATA_W-1:0] fall;
    logic                   parity_error;
  } dmio_rd_type;

  typedef struct packed {
    logic [DMIO_CMD_W-1:0]  cmd;
    logic [DMIO_ADDR_W-1:0] addr;
  } dmio_cmd_type;

  // lane data plus optional parity bit onto the pins of group 0, and of both groups in wide mode
  function automatic logic [DMIO_PIN_W-1:0] dmio_to_pins(input logic [DMIO_DATA_W-1:0] d,
                                                       input logic par_en, input logic wide);
    logic [DMIO_PIN_W-1:0] p;
    p = '0;
    for (int g = 0; g < DMIO_GROUPS; g++) begin
      if (g == 0 || wide) begin
        p[g*DMIO_LANE_PINS +: DMIO_LANE_DATA] = d[g*DMIO_LANE_DATA +: DMIO_LANE_DATA];
        p[g*DMIO_LANE_PINS + DMIO_LANE_DATA]  = par_en & (^d[g*DMIO_LANE_DATA +: DMIO_LANE_DATA]);
      end
    end
    return p;
  endfunction

  function automatic logic [DMIO_DATA_W-1:0] dmio_from_pins(input logic [DMIO_PIN_W-1:0] p,
                                                           input logic wide);
    logic [DMIO_DATA_W-1:0] d;
    d = '0;
    for (int g = 0; g < DMIO_GROUPS; g++) begin
      if (g == 0 || wide) begin
        d[g*DMIO_LANE_DATA +: DMIO_LANE_DATA] = p[g*DMIO_LANE_PINS +: DMIO_LANE_DATA];
      end
    end
    return d;
  endfunction

  function automatic logic dmio_parity_bad(input logic [DMIO_PIN_W-1:0] p,
                                           input logic par_en, input logic wide);
    logic bad;
    bad = 1'b0;
    for (int g = 0; g < DMIO_GROUPS; g++) begin
      if (par_en && (g == 0 || wide)) begin
        bad = bad | (^p[g*DMIO_LANE_PINS +: DMIO_LANE_PINS]);
      end
    end
    return bad;
  endfunction
endpackage
`default_nettype wire

// file: verilog/dmio_datapath.sv
// Operation
// - every bank runs single and double rate memory up to 167 MHz, 333 Mbps.
// - dedicated interface runs 167 MHz for DDR/DDR2, 667 Mbps for QDRII.
// - each strobe group configures as an x8/x9 or x16/x18 bus.
// - a group is one strobe, one mask and at most nine data pins.
// - read timing comes from a two-way strobe or one-way read clock.
// - programmable delay picks one of four strobe-clocked stages behind the captured read data.
// - undelayed read strobe clocks read data into logic cell registers on both edges.
// - the ninth pin of each group may carry parity, one bit per eight data bits.
// - mask driven low on each lane whose write data is valid.
// - each strobe and data group has its own mask pin.
// - interface runs from one system clock, using both of its edges.
// - system clock launches write strobe, commands and addresses.
// - falling system edge, a quarter memory period later, launches write data.
`timescale 1ns/1ps
`default_nettype none

module dmio_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             in_clock,
  input  wire logic             in_nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             out_clock,
  input  wire logic             out_nrst,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin;
  logic [AW:0]      next_wbin;
  logic [AW:0]      wgray;
  logic [AW:0]      rbin;
  logic [AW:0]      next_rbin;
  logic [AW:0]      rgray;
  logic [AW:0]      rgray_meta;
  logic [AW:0]      rgray_sync;
  logic [AW:0]      wgray_meta;
  logic [AW:0]      wgray_sync;
  logic             push;
  logic             pop;

  always_comb begin
    in_ready  = wgray != {~rgray_sync[AW:AW-1], rgray_sync[AW-2:0]};
    push      = in_valid & in_ready;
    next_wbin = wbin + {{AW{1'b0}}, push};
    out_valid = rgray != wgray_sync;
    pop       = out_valid & out_ready;
    next_rbin = rbin + {{AW{1'b0}}, pop};
    out_data  = mem[rbin[AW-1:0]];
  end

  always_ff @(posedge in_clock or negedge in_nrst) begin
    if (!in_nrst) begin
      wbin       <= '0;
      wgray      <= '0;
      rgray_meta <= '0;
      rgray_sync <= '0;
    end else begin
      wbin       <= next_wbin;
      wgray      <= to_gray(next_wbin);
      rgray_meta <= rgray;
      rgray_sync <= rgray_meta;
    end
  end

  always_ff @(posedge in_clock) begin
    if (push) begin
      mem[wbin[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge out_clock or negedge out_nrst) begin
    if (!out_nrst) begin
      rbin       <= '0;
      rgray      <= '0;
      wgray_meta <= '0;
      wgray_sync <= '0;
    end else begin
      rbin       <= next_rbin;
      rgray      <= to_gray(next_rbin);
      wgray_meta <= wgray;
      wgray_sync <= wgray_meta;
    end
  end
endmodule // dmio_fifo

module dmio_datapath
  import dmio_pkg::*;
#(
  parameter int FIFO_DEPTH = DMIO_FIFO_DEPTH,
  parameter int DELAY_TAPS = DMIO_DELAY_TAPS
) (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    read_strobe,
  input  wire logic [DMIO_PIN_W-1:0]   dq_in,
  output logic      [DMIO_PIN_W-1:0]   dq_out,
  output logic      [DMIO_GROUPS-1:0]  dq_oe_n,
  output logic                         strobe_out,
  output logic                         strobe_oe_n,
  output logic      [DMIO_GROUPS-1:0]  mask_out,
  output logic                         mem_clk,
  output dmio_cmd_type                 cmd_out,
  input  wire logic                    wide_mode,
  input  wire logic                    parity_en,
  input  wire logic                    strobe_bidir,
  input  wire logic [DMIO_TAP_W-1:0]   strobe_delay,
  input  wire logic                    read_enable,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  input  wire dmio_cmd_type            cmd_in,
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  input  wire dmio_wr_type             wr_word,
  output logic                         rd_valid,
  input  wire logic                    rd_ready,
  output dmio_rd_type                  rd_word,
  output logic                         capture_ready
);
  // system clock domain
  logic                   rst_meta;
  logic                   rst_n;
  logic                   phase;
  logic                   next_phase;
  logic                   launch;
  dmio_wstate_type        state;
  dmio_wstate_type        next_state;
  dmio_cmd_type           next_cmd;
  dmio_beats_type         beats;
  dmio_beats_type         next_beats;
  logic [DMIO_GROUPS-1:0] mask_hold;
  logic [DMIO_GROUPS-1:0] next_mask_hold;
  logic                   next_strobe;
  logic                   next_strobe_oe_n;
  logic [DMIO_PIN_W-1:0]  next_dq;
  logic [DMIO_GROUPS-1:0] next_dq_oe_n;
  logic [DMIO_GROUPS-1:0] next_mask_out;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // memory clock is the system clock halved; each rising edge is a launch point
  always_comb begin
    next_phase       = ~phase;
    launch           = ~phase;
    cmd_ready        = launch;
    wr_ready         = launch & ((state == DMIO_PRE) | (state == DMIO_WRITE));
    next_state       = state;
    next_cmd         = cmd_out;
    next_beats       = beats;
    next_mask_hold   = mask_hold;
    if (launch) begin
      next_cmd = cmd_valid ? cmd_in : dmio_cmd_type'{cmd: DMIO_CMD_NOP, addr: cmd_out.addr};
      case (state)
        DMIO_IDLE: begin
          if (wr_valid) begin
            next_state = DMIO_PRE;
          end
        end
        DMIO_PRE, DMIO_WRITE: begin
          if (wr_valid) begin
            next_state      = DMIO_WRITE;
            next_beats.rise = dmio_to_pins(wr_word.rise, parity_en, wide_mode);
            next_beats.fall = dmio_to_pins(wr_word.fall, parity_en, wide_mode);
            next_mask_hold  = ~wr_word.lane_en;
          end else begin
            next_state = DMIO_POST;
          end
        end
        DMIO_POST: begin
          next_state = DMIO_IDLE;
        end
        default: begin
          next_state = DMIO_IDLE;
        end
      endcase
    end
    next_strobe      = next_phase & (next_state == DMIO_WRITE);
    next_strobe_oe_n = ~strobe_bidir | (next_state == DMIO_IDLE);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase       <= 1'b0;
      state       <= DMIO_IDLE;
      cmd_out     <= '{cmd: DMIO_CMD_NOP, addr: '0};
      beats       <= '0;
      mask_hold   <= '1;
      strobe_out  <= 1'b0;
      strobe_oe_n <= 1'b1;
    end else begin
      phase       <= next_phase;
      state       <= next_state;
      cmd_out     <= next_cmd;
      beats       <= next_beats;
      mask_hold   <= next_mask_hold;
      strobe_out  <= next_strobe;
      strobe_oe_n <= next_strobe_oe_n;
    end
  end

  assign mem_clk = phase;

  // write data leaves on the falling system edge, a quarter memory period late
  always_comb begin
    next_dq = phase ? beats.rise : beats.fall;
    for (int g = 0; g < DMIO_GROUPS; g++) begin
      next_dq_oe_n[g]  = ~((state == DMIO_WRITE) & ((g == 0) | wide_mode));
      next_mask_out[g] = mask_hold[g] | ~(state == DMIO_WRITE) | ~((g == 0) | wide_mode);
    end
  end

  always_ff @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dq_out   <= '0;
      dq_oe_n  <= '1;
      mask_out <= '1;
    end else begin
      dq_out   <= next_dq;
      dq_oe_n  <= next_dq_oe_n;
      mask_out <= next_mask_out;
    end
  end

  // strobe domain
  localparam int CFG_W = DMIO_TAP_W + 3;
  logic                  lrst_meta;
  logic                  lrst_n;
  logic [CFG_W-1:0]      cfg_meta;
  logic [CFG_W-1:0]      cfg_sync;
  logic [DMIO_PIN_W-1:0] rise_cap;
  logic [DMIO_PIN_W-1:0] fall_cap;
  dmio_beats_type        pipe [DELAY_TAPS];
  dmio_beats_type        next_pipe [DELAY_TAPS];
  logic [DELAY_TAPS-1:0] pipe_valid;
  logic [DELAY_TAPS-1:0] next_pipe_valid;
  dmio_beats_type        sel;
  logic                  sel_valid;
  logic                  l_wide;
  logic                  l_par;
  logic                  l_rden;
  logic [DMIO_TAP_W-1:0] l_tap;
  dmio_rd_type           cap_word;
  logic [$bits(dmio_rd_type)-1:0] rd_bits;

  always_ff @(posedge read_strobe or negedge nrst) begin
    if (!nrst) begin
      lrst_meta <= 1'b0;
      lrst_n    <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n    <= lrst_meta;
    end
  end

  always_ff @(posedge read_strobe or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_meta <= '0;
      cfg_sync <= '0;
    end else begin
      cfg_meta <= {read_enable, wide_mode, parity_en, strobe_delay};
      cfg_sync <= cfg_meta;
    end
  end

  // both strobe edges capture read data into logic cell registers
  always_ff @(posedge read_strobe) begin
    rise_cap <= dq_in;
  end

  always_ff @(negedge read_strobe) begin
    fall_cap <= dq_in;
  end

  always_comb begin
    {l_rden, l_wide, l_par, l_tap} = cfg_sync;
    next_pipe[0]       = '{rise: rise_cap, fall: fall_cap};
    next_pipe_valid[0] = l_rden;
    for (int i = 1; i < DELAY_TAPS; i++) begin
      next_pipe[i]       = pipe[i-1];
      next_pipe_valid[i] = pipe_valid[i-1];
    end
    sel       = pipe[l_tap];
    sel_valid = pipe_valid[l_tap];
    cap_word.rise = dmio_from_pins(sel.rise, l_wide);
    cap_word.fall = dmio_from_pins(sel.fall, l_wide);
    cap_word.parity_error = dmio_parity_bad(sel.rise, l_par, l_wide) |
                            dmio_parity_bad(sel.fall, l_par, l_wide);
  end

  always_ff @(posedge read_strobe) begin
    pipe <= next_pipe;
  end

  always_ff @(posedge read_strobe or negedge lrst_n) begin
    if (!lrst_n) begin
      pipe_valid <= '0;
    end else begin
      pipe_valid <= next_pipe_valid;
    end
  end

  dmio_fifo #(
    .WIDTH ($bits(dmio_rd_type)),
    .DEPTH (FIFO_DEPTH)
  ) read_fifo (
    .in_clock  (read_strobe),
    .in_nrst   (lrst_n),
    .in_valid  (sel_valid),
    .in_ready  (capture_ready),
    .in_data   (cap_word),
    .out_clock (clock),
    .out_nrst  (rst_n),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_bits)
  );

  assign rd_word = rd_bits;
endmodule // dmio_datapath
`default_nettype wire

// file: bench/dmio_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dmio_checker
  import dmio_pkg::*;
(
  input wire logic                   clock,
  input wire logic                   nrst,
  input wire logic                   cmd_valid,
  input wire logic                   cmd_ready,
  input wire dmio_cmd_type           cmd_in,
  input wire dmio_cmd_type           cmd_out,
  input wire logic                   mem_clk,
  input wire logic                   wr_valid,
  input wire logic                   wr_ready,
  input wire dmio_wr_type            wr_word,
  input wire logic                   strobe_out,
  input wire logic                   strobe_oe_n,
  input wire logic                   strobe_bidir,
  input wire logic                   wide_mode,
  input wire logic [DMIO_GROUPS-1:0] dq_oe_n,
  input wire logic [DMIO_GROUPS-1:0] mask_out
);
  logic [1:0] up;
  wire logic  on = (up == 2'h3);
  // skips the internal reset release cycles
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_cmd_launch: assert property (on && cmd_valid && cmd_ready |=> cmd_out == $past(cmd_in))
    else $error("command not launched");
  a_cmd_nop: assert property (on && cmd_ready && !cmd_valid |=> cmd_out.cmd == DMIO_CMD_NOP)
    else $error("idle launch not nop");
  a_mem_clk_phase: assert property (on && cmd_ready |=> mem_clk && !cmd_ready ##1 !mem_clk && cmd_ready)
    else $error("memory clock phase wrong");
  a_oneway_strobe: assert property (!strobe_bidir |-> strobe_oe_n)
    else $error("one-way strobe driven");
  a_idle_mask: assert property (dq_oe_n[0] |-> mask_out[0])
    else $error("mask low while idle");
  a_narrow_group: assert property (!wide_mode |-> dq_oe_n[1] && mask_out[1])
    else $error("upper group active in narrow mode");
  a_write_phase: assert property (wr_ready |-> cmd_ready)
    else $error("write taken off launch edge");
  a_write_strobe: assert property (wr_valid && wr_ready |=> strobe_out ##1 !strobe_out)
    else $error("write strobe wrong");
  a_write_mask: assert property (wr_valid && wr_ready |-> ##2 mask_out[0] == !$past(wr_word.lane_en[0], 2))
    else $error("mask not from lane enable");
  c_cmd: cover property (cmd_valid && cmd_ready);
  c_write: cover property (wr_valid && wr_ready);
  c_strobe: cover property (!strobe_oe_n);
endmodule // dmio_checker
bind dmio_datapath dmio_checker i_chk (.clock(clock), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_in(cmd_in), .cmd_out(cmd_out), .mem_clk(mem_clk), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_word(wr_word), .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
  .strobe_bidir(strobe_bidir), .wide_mode(wide_mode), .dq_oe_n(dq_oe_n), .mask_out(mask_out));
`default_nettype wire

// file: bench/dmio_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmio_mem_model
  import dmio_pkg::*;
(
  input  wire logic [DMIO_PIN_W-1:0]  dq_out,
  input  wire logic [DMIO_GROUPS-1:0] dq_oe_n,
  input  wire logic [DMIO_GROUPS-1:0] mask_out,
  input  wire logic                   clock,
  input  wire logic                   go,
  input  wire logic                   bad_par,
  output logic                        read_strobe,
  output logic      [DMIO_PIN_W-1:0]  dq_in
);
  logic [8:0] wq[$];
  logic [7:0] b;
  function automatic logic [DMIO_PIN_W-1:0] beat(input logic [7:0] v);
    return {^v, ~v, ^v ^ bad_par, v};
  endfunction
  // keeps written lane 0 pins only while its mask is low
  always @(posedge clock) begin
    if (dq_oe_n[0] === 1'b0 && mask_out[0] === 1'b0) wq.push_back(dq_out[8:0]);
  end
  // read clock runs only in frames, strobe edges sit mid-window
  initial begin
    read_strobe = 1'b0;
    dq_in = '0;
    b = 8'h00;
    forever begin
      wait (go === 1'b1);
      dq_in = beat(b);
      #7.5 read_strobe = 1'b1;
      #7.5 dq_in = beat(b + 8'h01);
      #7.5 read_strobe = 1'b0;
      #7.5 b = b + 8'h02;
      if (go !== 1'b1) dq_in = ~dq_in;
    end
  end
endmodule // dmio_mem_model
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dmio_pkg::*;
;
  logic clock, nrst, read_strobe, strobe_out, strobe_oe_n, mem_clk, wide_mode, parity_en, strobe_bidir;
  logic read_enable, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, rd_ready, capture_ready, go, bad_par;
  logic [DMIO_PIN_W-1:0]  dq_in, dq_out;
  logic [DMIO_GROUPS-1:0] dq_oe_n, mask_out;
  logic [DMIO_TAP_W-1:0]  strobe_delay;
  dmio_cmd_type           cmd_in, cmd_out;
  dmio_wr_type            wr_word;
  dmio_rd_type            rd_word;
  dmio_rd_type            got[$];
  int                     err_count, checked;
  dmio_datapath i_dut (.*);
  dmio_mem_model i_mem (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic complete_run;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_rdy(input bit w);
    int n;
    n = 0;
    while ((w ? wr_ready : cmd_ready) !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    if ((w ? wr_ready : cmd_ready) !== 1'b1) begin
      err_count++;
      complete_run;
    end
  endtask
  task automatic frame(input int n);
    read_enable = 1'b1;
    go = 1'b1;
    step(n * 6);
    read_enable = 1'b0;
    step(36);
    go = 1'b0;
    step(30);
  endtask
  task automatic drain;
    got.delete();
    rd_ready = 1'b1;
    for (int k = 0; k < 40; k++) begin
      if (rd_valid === 1'b1) got.push_back(rd_word);
      step(1);
    end
    rd_ready = 1'b0;
  endtask
  task automatic t_cmd;
    dmio_cmd_type c;
    for (int i = 1; i < 4; i++) begin
      c = '{cmd: 4'(i), addr: 13'(i * 3)};
      cmd_in = c;
      cmd_valid = 1'b1;
      wait_rdy(1'b0);
      step(1);
      check(cmd_out, c);
    end
    cmd_valid = 1'b0;
    step(2);
    check(cmd_out.cmd, DMIO_CMD_NOP);
    $display("test cmd done");
  endtask
  task automatic t_write(input logic [1:0] en);
    dmio_wr_type w[2];
    logic [8:0]  exp[$];
    w[0] = '{rise: 16'h5a3c, fall: 16'h0f96, lane_en: en};
    w[1] = '{rise: 16'hc381, fall: 16'h7e24, lane_en: en};
    i_mem.wq.delete();
    for (int k = 0; k < 2; k++) begin
      wr_word = w[k];
      wr_valid = 1'b1;
      wait_rdy(1'b1);
      step(1);
      if (k == 0) check(strobe_oe_n, !strobe_bidir);
      if (en[0]) exp.push_back({parity_en & (^w[k].rise[7:0]), w[k].rise[7:0]});
      if (en[0]) exp.push_back({parity_en & (^w[k].fall[7:0]), w[k].fall[7:0]});
    end
    wr_valid = 1'b0;
    step(12);
    check(i_mem.wq.size(), exp.size());
    foreach (exp[k]) check(i_mem.wq[k], exp[k]);
    $display("test write %b done", en);
  endtask
  task automatic t_read(input logic [1:0] tap, input logic w, input logic pe, input logic bad);
    strobe_delay = tap;
    wide_mode = w;
    strobe_bidir = w;
    parity_en = pe;
    bad_par = bad;
    step(4);
    frame(10);
    drain;
    check(got.size() > 3, 1'b1);
    foreach (got[k]) begin
      check(got[k].fall[7:0], 8'(got[k].rise[7:0] + 8'h01));
      if (w) check(got[k].rise[15:8], 8'(~got[k].rise[7:0]));
      check(got[k].parity_error, pe & bad);
      if (k > 0) check(got[k].rise[7:0], 8'(got[k-1].rise[7:0] + 8'h02));
    end
    $display("test read tap %0d done", tap);
  endtask
  task automatic t_full;
    frame(16);
    check(capture_ready, 1'b0);
    drain;
    check(got.size(), DMIO_FIFO_DEPTH);
    $display("test full done");
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    complete_run;
  end
  initial begin
    nrst = 1'b0;
    {go, bad_par, strobe_delay, read_enable, cmd_valid, wr_valid, rd_ready} = '0;
    {wide_mode, parity_en, strobe_bidir} = 3'h7;
    cmd_in = '0;
    wr_word = '0;
    err_count = 0;
    checked = 0;
    step(6);
    nrst = 1'b1;
    step(3);
    t_cmd;
    t_write(2'h3);
    t_write(2'h2);
    t_read(2'h0, 1'b1, 1'b1, 1'b0);
    t_read(2'h3, 1'b1, 1'b1, 1'b1);
    t_read(2'h1, 1'b0, 1'b0, 1'b1);
    t_write(2'h3);
    t_full;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
